/* File: pkg/rps_defines.svh */
// offsets, field positions, reset values and select codes of the
// buffer ram pointer and indirect select register bank.
// assumes a byte-addressed avalon-mm slave with one 32-bit word per register.
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH
// ==========================================
// register byte offsets
`define RPS_OFS_PTR_UPPER 8'h00
`define RPS_OFS_PTR_LOWER 8'h04
`define RPS_OFS_SELECT 8'h08
`define RPS_OFS_CONFIG 8'h0C
`define RPS_OFS_SHARED 8'h10
`define RPS_OFS_RAM_DATA 8'h14
`define RPS_OFS_STATUS 8'h18
`define RPS_OFS_DIAG 8'h1C
// ==========================================
// field positions
`define RPS_DIR_BIT 7
`define RPS_STEP_BIT 6
`define RPS_SWRST_BIT 7
`define RPS_CHAIN_BIT 6
// ==========================================
// indirect select codes
`define RPS_SEL_TENT 3'h0
`define RPS_SEL_NODE 3'h1
`define RPS_SEL_SETUP1 3'h2
`define RPS_SEL_NEXT 3'h3
`define RPS_SEL_SETUP2 3'h4
// ==========================================
// reset values
`define RPS_PTR_RST 11'h000
`define RPS_CFG_RST 8'h00
`define RPS_SEL_RST 3'h0
`define RPS_STATUS_RST 8'h00
`define RPS_DIAG_RST 8'h00
`define RPS_NEXTID_RST 8'h00
`define RPS_ID_RST 8'h00
`define RPS_RSVD_READ 8'h00
`endif

/* File: pkg/rps_pkg.sv */
// types shared by the pointer and indirect select register bank.
// assumes nothing beyond a systemverilog compiler.
package rps_pkg;
  // ==========================================
  // bus access sequencer states
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_RD1 = 4'b0010,
    ST_RD2 = 4'b0100,
    ST_ACK = 4'b1000
  } rps_state_e;
endpackage

/* File: design/rps_pointer.sv */
// 11-bit buffer ram address pointer with direction and step enable.
// assumes load and step strobes are one-cycle pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.svh"
module rps_pointer
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic load_upper, // write to upper pointer register
  input wire logic load_lower, // write to lower pointer register
  input wire logic step, // one data access completed
  input wire logic [7:0] wdata,
  output logic [7:0] upper_rd, // readback of upper register
  output logic [10:0] ptr, // full ram address
  output logic ptr_dir // 1 read prepared, 0 write
);
  logic dir_r; // access direction
  logic step_en_r; // pointer step enable
  logic [10:0] ptr_r; // pointer_upper_bits and pointer_lower_bits

  // ==========================================
  // pointer state
  // loads win over a step; software is not expected to do both at once
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      dir_r <= 1'b0;
      step_en_r <= 1'b0;
      ptr_r <= `RPS_PTR_RST;
    end
    else if (load_upper)
    begin
      dir_r <= wdata[`RPS_DIR_BIT];
      step_en_r <= wdata[`RPS_STEP_BIT];
      ptr_r[10:8] <= wdata[2:0];
    end
    else if (load_lower)
    begin
      ptr_r[7:0] <= wdata;
    end
    else if (step && step_en_r)
    begin
      // single 11-bit add so the low byte carries upward
      ptr_r <= 11'(ptr_r + 11'h001);
    end
  end

  // unused bits 5..3 read as zero
  assign upper_rd = {dir_r, step_en_r, 3'h0, ptr_r[10:8]};
  assign ptr = ptr_r;
  assign ptr_dir = dir_r;

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_step_carry: assert property (step && step_en_r && !load_upper && !load_lower
    |=> ptr_r == 11'($past(ptr_r) + 11'h001)) else $error("pointer did not step");
  a_step_hold: assert property (step && !step_en_r && !load_upper && !load_lower
    |=> $stable(ptr_r)) else $error("pointer moved with step off");
  a_upper_bits: assert property (load_upper
    |=> ptr_r[10:8] == $past(wdata[2:0])) else $error("upper bits not loaded");
  a_lower_bits: assert property (load_lower && !load_upper
    |=> ptr_r[7:0] == $past(wdata)) else $error("lower bits not loaded");
endmodule
`default_nettype wire

/* File: design/rps_indirect.sv */
// indirect id and setup registers seen through the shared location.
// assumes write and load strobes are one-cycle pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.svh"
module rps_indirect
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] sel, // indirect_select
  input wire logic wr, // write to the shared location
  input wire logic [7:0] wdata,
  input wire logic sw_reset, // software reset level
  input wire logic next_id_load, // protocol engine updates next id
  input wire logic [7:0] next_id_in,
  output logic [7:0] rdata, // shared location readback
  output logic [7:0] tentative_id,
  output logic [7:0] node_id,
  output logic [7:0] setup_one,
  output logic [7:0] next_id,
  output logic [7:0] setup_two
);
  logic [7:0] store_r [0:4]; // one flop byte per valid code

  // ==========================================
  // one byte per select code
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1)
    begin : g_ent
      if (i == 3)
      begin : g_next
        // next id is written by hardware only; soft reset clears it
        always_ff @(posedge mclk or negedge nrst)
        begin
          if (!nrst)
            store_r[i] <= `RPS_NEXTID_RST;
          else if (sw_reset)
            store_r[i] <= `RPS_NEXTID_RST;
          else if (next_id_load)
            store_r[i] <= next_id_in;
        end
      end
      else
      begin : g_rw
        always_ff @(posedge mclk or negedge nrst)
        begin
          if (!nrst)
            store_r[i] <= `RPS_ID_RST;
          else if (wr && sel == 3'(i))
            store_r[i] <= wdata;
        end
      end
    end
  endgenerate

  // reserved codes read a fixed value and swallow writes
  assign rdata = (sel <= `RPS_SEL_SETUP2) ? store_r[sel] : `RPS_RSVD_READ;
  assign tentative_id = store_r[0];
  assign node_id = store_r[1];
  assign setup_one = store_r[2];
  assign next_id = store_r[3];
  assign setup_two = store_r[4];

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_rsvd_ignore: assert property (wr && sel > `RPS_SEL_SETUP2
    |=> $stable(tentative_id) && $stable(node_id) && $stable(setup_one)
    && $stable(setup_two)) else $error("reserved code changed a register");
  a_sel_write: assert property (wr && sel == `RPS_SEL_NODE
    |=> node_id == $past(wdata)) else $error("node id not written");
  c_rsvd_write: cover property (wr && sel > `RPS_SEL_SETUP2);
endmodule
`default_nettype wire

/* File: design/rps_top.sv */
// avalon-mm register bank: buffer ram pointer, indirect select and
// the software reset and chaining bits of the configuration register.
// assumes a synchronous 2k x 8 ram outside: data one cycle after ram_re.
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.svh"
module rps_top
(
  input wire logic mclk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // buffer ram port
  output logic [10:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic ram_re,
  input wire logic [7:0] ram_rdata,
  // protocol engine side
  input wire logic [7:0] status_set,
  input wire logic [7:0] diag_set,
  input wire logic next_id_load,
  input wire logic [7:0] next_id_in,
  output logic soft_reset,
  output logic chain_mode_enable,
  output logic [7:0] tentative_id,
  output logic [7:0] node_id,
  output logic [7:0] setup_one,
  output logic [7:0] next_id,
  output logic [7:0] setup_two
);
  // ==========================================
  // declarations
  rps_pkg::rps_state_e state_r; // bus sequencer
  rps_pkg::rps_state_e state_nxt;
  logic [31:0] readdata_r; // answer word
  logic wait_r; // waitrequest
  logic [10:0] ram_addr_r;
  logic [7:0] ram_wdata_r;
  logic ram_we_r;
  logic ram_re_r;
  logic [7:0] cfg_r; // device_configuration
  logic [2:0] sel_r; // indirect_select
  logic [7:0] status_r; // status register
  logic [7:0] diag_r; // diagnostic status
  logic [7:0] upper_rd; // upper pointer readback
  logic [10:0] ptr; // current pointer
  logic ptr_dir; // access_direction
  logic [7:0] shared_rd; // shared location readback
  logic [7:0] rd_mux; // register readback byte
  logic commit; // master samples waitrequest low now
  logic wr_commit; // byte lane 0 write takes effect
  logic hit_ram; // address is the ram data port
  logic ram_rd_go; // read that needs a ram fetch
  logic load_upper;
  logic load_lower;
  logic load_sel;
  logic load_cfg;
  logic shared_wr;
  logic step; // one data access completed
  logic [7:0] wbyte; // low byte of write data

  // ==========================================
  // access decode, qualified by the answer edge
  assign wbyte = avs_writedata[7:0];
  assign hit_ram = (avs_address == `RPS_OFS_RAM_DATA);
  assign commit = (state_r == rps_pkg::ST_ACK);
  assign wr_commit = commit && avs_write && avs_byteenable[0];
  assign ram_rd_go = avs_read && hit_ram && ptr_dir;
  assign load_upper = wr_commit && (avs_address == `RPS_OFS_PTR_UPPER);
  assign load_lower = wr_commit && (avs_address == `RPS_OFS_PTR_LOWER);
  assign load_sel = wr_commit && (avs_address == `RPS_OFS_SELECT);
  assign load_cfg = wr_commit && (avs_address == `RPS_OFS_CONFIG);
  assign shared_wr = wr_commit && (avs_address == `RPS_OFS_SHARED);

  // a refused data access leaves the pointer alone
  // a data access counts only in the prepared direction
  assign step = commit && hit_ram
    && ((avs_read && ptr_dir) || (wr_commit && !ptr_dir));

  // ==========================================
  // pointer and indirect registers
  // the pointer also owns direction and step enable
  rps_pointer u_ptr
  (
    .mclk(mclk),
    .nrst(nrst),
    .load_upper(load_upper),
    .load_lower(load_lower),
    .step(step),
    .wdata(wbyte),
    .upper_rd(upper_rd),
    .ptr(ptr),
    .ptr_dir(ptr_dir)
  );

  // soft reset reaches this bank only as the next id clear
  rps_indirect u_ind
  (
    .mclk(mclk),
    .nrst(nrst),
    .sel(sel_r),
    .wr(shared_wr),
    .wdata(wbyte),
    .sw_reset(cfg_r[`RPS_SWRST_BIT]),
    .next_id_load(next_id_load),
    .next_id_in(next_id_in),
    .rdata(shared_rd),
    .tentative_id(tentative_id),
    .node_id(node_id),
    .setup_one(setup_one),
    .next_id(next_id),
    .setup_two(setup_two)
  );

  // ==========================================
  // bus sequencer: register reads answer in one cycle, ram reads in three
  // the answer edge always returns to idle, one idle edge per request
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      rps_pkg::ST_IDLE:
      begin
        if (avs_read && ram_rd_go)
          state_nxt = rps_pkg::ST_RD1;
        else if (avs_read || avs_write)
          state_nxt = rps_pkg::ST_ACK;
      end
      rps_pkg::ST_RD1: state_nxt = rps_pkg::ST_RD2; // ram samples address
      rps_pkg::ST_RD2: state_nxt = rps_pkg::ST_ACK; // ram data valid
      rps_pkg::ST_ACK: state_nxt = rps_pkg::ST_IDLE; // master releases
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      state_r <= rps_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // ==========================================
  // read mux; unmapped offsets read zero
  always_comb
  begin
    unique case (avs_address)
      `RPS_OFS_PTR_UPPER: rd_mux = upper_rd;
      `RPS_OFS_PTR_LOWER: rd_mux = ptr[7:0];
      `RPS_OFS_SELECT: rd_mux = {5'h00, sel_r};
      `RPS_OFS_CONFIG: rd_mux = cfg_r;
      `RPS_OFS_SHARED: rd_mux = shared_rd;
      `RPS_OFS_STATUS: rd_mux = status_r;
      `RPS_OFS_DIAG: rd_mux = diag_r;
      default: rd_mux = 8'h00; // ram data without a read prepared, unmapped
    endcase
  end

  // ==========================================
  // waitrequest and read data
  // waitrequest idles high so the master always waits for a real answer
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_r <= 1'b1;
      readdata_r <= 32'h00000000;
    end
    else if (state_nxt == rps_pkg::ST_ACK)
    begin
      wait_r <= 1'b0;
      // rd2 is the cycle in which the ram shows the byte
      if (state_r == rps_pkg::ST_RD2)
        readdata_r <= {24'h000000, ram_rdata};
      else
        readdata_r <= {24'h000000, rd_mux};
    end
    else
    begin
      wait_r <= 1'b1;
    end
  end

  // ==========================================
  // ram port: address follows the pointer one cycle late
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ram_addr_r <= `RPS_PTR_RST;
      ram_wdata_r <= 8'h00;
      ram_we_r <= 1'b0;
      ram_re_r <= 1'b0;
    end
    else
    begin
      ram_addr_r <= ptr;
      // read strobe only for a prepared data read
      ram_re_r <= (state_nxt == rps_pkg::ST_RD1);
      // write data goes out with the pre-step pointer in ram_addr_r
      ram_we_r <= wr_commit && hit_ram && !ptr_dir;
      // data latched even when refused; ram_we alone decides
      if (wr_commit && hit_ram)
        ram_wdata_r <= wbyte;
    end
  end

  // ==========================================
  // select and configuration; neither is touched by soft reset
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_r <= `RPS_SEL_RST;
      cfg_r <= `RPS_CFG_RST;
    end
    else
    begin
      // only three select bits kept; upper bits read zero
      if (load_sel)
        sel_r <= wbyte[2:0];
      if (load_cfg)
        cfg_r <= wbyte;
    end
  end

  // ==========================================
  // status and diagnostics: sticky sets, held clear during soft reset
  // while the reset bit stands the clear dominates incoming sets
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_r <= `RPS_STATUS_RST;
      diag_r <= `RPS_DIAG_RST;
    end
    else if (cfg_r[`RPS_SWRST_BIT])
    begin
      status_r <= `RPS_STATUS_RST;
      diag_r <= `RPS_DIAG_RST;
    end
    else
    begin
      // bits stay set until the next soft reset
      status_r <= status_r | status_set;
      diag_r <= diag_r | diag_set;
    end
  end

  // ==========================================
  // outputs
  assign avs_readdata = readdata_r;
  assign avs_waitrequest = wait_r;
  assign ram_addr = ram_addr_r;
  assign ram_wdata = ram_wdata_r;
  assign ram_we = ram_we_r;
  assign ram_re = ram_re_r;
  // the device stays in soft reset while the bit stands
  assign soft_reset = cfg_r[`RPS_SWRST_BIT];
  // low keeps the legacy single-command behaviour downstream
  assign chain_mode_enable = cfg_r[`RPS_CHAIN_BIT];

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // register and write accesses answer one cycle after they are taken
  a_reg_answer: assert property (state_r == rps_pkg::ST_IDLE && (avs_read || avs_write)
    && !ram_rd_go |=> !avs_waitrequest) else $error("register access not answered");
  // a prepared ram read needs a fetch cycle and a data cycle first
  a_ram_read_lat: assert property (state_r == rps_pkg::ST_IDLE && ram_rd_go
    |-> ##1 ram_re ##2 !avs_waitrequest) else $error("ram read latency wrong");
  // the master waits while idle and is let go for one cycle only
  a_idle_wait: assert property (state_r == rps_pkg::ST_IDLE |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ack_state: assert property (!avs_waitrequest |-> state_r == rps_pkg::ST_ACK)
    else $error("answer outside the answer state");
  // strobes to the ram are single pulses carrying the taken byte
  a_re_pulse: assert property (ram_re |=> !ram_re) else $error("ram read strobe too long");
  a_we_pulse: assert property (ram_we |=> !ram_we) else $error("ram write strobe too long");
  a_we_data: assert property (ram_we |-> ram_wdata == $past(wbyte))
    else $error("ram write data wrong");
  a_ram_we_dir: assert property (ram_we |-> !$past(ptr_dir))
    else $error("ram written while read prepared");
  // a data read with write prepared never reaches the ram
  a_ram_no_fetch: assert property (state_r == rps_pkg::ST_IDLE && avs_read
    && hit_ram && !ptr_dir |=> !ram_re) else $error("ram fetched with write prepared");
  a_ram_addr: assert property (ram_re |-> ram_addr == ptr)
    else $error("ram address not pointer");
  // register loads
  a_dir_load: assert property (load_upper |=> ptr_dir == $past(wbyte[`RPS_DIR_BIT]))
    else $error("direction bit not loaded");
  a_sel_load: assert property (load_sel |=> sel_r == $past(wbyte[2:0]))
    else $error("select field not loaded");
  a_cfg_load: assert property (load_cfg |=> cfg_r == $past(wbyte))
    else $error("configuration not loaded");
  a_chain_bit: assert property (load_cfg |=> chain_mode_enable == $past(wbyte[6]))
    else $error("chain enable not loaded");
  // soft reset
  a_swrst_set: assert property (load_cfg && wbyte[`RPS_SWRST_BIT]
    |=> soft_reset ##1 status_r == `RPS_STATUS_RST) else $error("soft reset not taken");
  a_swrst_hold: assert property (soft_reset && !load_cfg |=> soft_reset)
    else $error("soft reset released by itself");
  a_swrst_keep: assert property (soft_reset && !load_cfg && !load_upper && !load_lower
    && !step |=> $stable(cfg_r) && $stable(ptr)) else $error("soft reset disturbed state");
  a_swrst_clear: assert property (soft_reset |=> status_r == `RPS_STATUS_RST
    && diag_r == `RPS_DIAG_RST && next_id == `RPS_NEXTID_RST)
    else $error("soft reset left status");
  // outside soft reset a set status bit never falls
  a_status_sticky: assert property (!soft_reset |=> (status_r & $past(status_r))
    == $past(status_r)) else $error("status bit lost");
  // main scenarios: ram read, ram write, soft reset, top wrap
  c_ram_read: cover property (ram_rd_go ##3 !avs_waitrequest);
  c_ram_write: cover property (ram_we);
  c_soft_reset: cover property (soft_reset ##1 !soft_reset);
  c_ptr_wrap: cover property (step && ptr == 11'h7FF);
endmodule
`default_nettype wire

/* File: testbench/rps_ram_model.sv */
// behavioural 2k x 8 synchronous buffer ram on the far side of the bank.
// assumes strobes come from mclk; read data one cycle after ram_re.
`timescale 1ns/1ps
`default_nettype none
module rps_ram_model
(
  input wire logic mclk,
  input wire logic [10:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [7:0] ram_rdata
);
  // ==========================================
  // storage
  logic [7:0] mem [0:2047]; // buffer contents
  // preload differs on the upper bits too, so a lost carry shows
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = i[7:0] ^ {5'h00, i[10:8]};
  end
  // write port
  always @(posedge mclk)
    if (ram_we)
      mem[ram_addr] <= ram_wdata;
  // read port; the bus toggles outside a read so a stale sample is caught
  always @(posedge mclk)
    if (ram_re)
      ram_rdata <= mem[ram_addr];
    else
      ram_rdata <= ~ram_rdata;
endmodule
`default_nettype wire

/* File: testbench/ram_pointer_and_subaddress_test.sv */
// self-checking bench for the pointer and indirect select bank.
// assumes rps_top, rps_ram_model and the defines header are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.svh"
module ram_pointer_and_subaddress_test;
  // ==========================================
  // offsets and signals
  localparam logic [7:0] UP = `RPS_OFS_PTR_UPPER;
  localparam logic [7:0] LO = `RPS_OFS_PTR_LOWER;
  localparam logic [7:0] SEL = `RPS_OFS_SELECT;
  localparam logic [7:0] CFG = `RPS_OFS_CONFIG;
  localparam logic [7:0] SH = `RPS_OFS_SHARED;
  localparam logic [7:0] RD = `RPS_OFS_RAM_DATA;
  localparam logic [7:0] ST = `RPS_OFS_STATUS;
  localparam logic [7:0] DG = `RPS_OFS_DIAG;
  logic mclk, nrst, avs_read, avs_write, avs_waitrequest; // clock, reset, bus
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q; // q holds the last read
  logic [3:0] avs_byteenable;
  logic [10:0] ram_addr;
  logic [7:0] ram_wdata, ram_rdata, status_set, diag_set, next_id_in;
  logic ram_we, ram_re, next_id_load, soft_reset, chain_mode_enable;
  logic [7:0] tentative_id, node_id, setup_one, next_id, setup_two;
  int err_total = 0; // mismatches
  int n_checks = 0; // comparisons
  typedef struct packed {logic [7:0] ofs; logic [7:0] wd; logic [7:0] exp;} rps_row_s;
  // plain write then read back; unmapped places read zero
  rps_row_s rows [0:6] = '{'{UP, 8'h85, 8'h85}, '{LO, 8'h5A, 8'h5A}, '{SEL, 8'h04, 8'h04},
    '{CFG, 8'h40, 8'h40}, '{CFG, 8'h00, 8'h00}, '{8'h20, 8'hFF, 8'h00}, '{8'hFC, 8'h5A, 8'h00}};
  // ==========================================
  // design and far-side ram
  rps_top DUT (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata),
    .status_set(status_set), .diag_set(diag_set), .next_id_load(next_id_load),
    .next_id_in(next_id_in), .soft_reset(soft_reset), .chain_mode_enable(chain_mode_enable),
    .tentative_id(tentative_id), .node_id(node_id), .setup_one(setup_one),
    .next_id(next_id), .setup_two(setup_two));
  rps_ram_model u_ram (.mclk(mclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));
  // ==========================================
  // clock, 8 ns period
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ==========================================
  // compare, bus and pulse tasks
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bounded wait for the answer edge; the request is still held here
  task automatic wait_ack;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic [3:0] be = 4'hF);
    @(posedge mclk);
    avs_address <= ofs;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ofs);
    @(posedge mclk);
    avs_address <= ofs;
    avs_read <= 1'b1;
    wait_ack();
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // read and compare against a byte in bits 7:0
  task automatic rdc(input string what, input logic [7:0] ofs, input logic [7:0] exp);
    rd(ofs);
    chk_val(what, {24'h000000, exp}, q);
  endtask
  // one-cycle pulses on the protocol engine inputs
  task automatic pulse(input logic [7:0] st, input logic [7:0] dg, input logic ld,
    input logic [7:0] nid);
    @(posedge mclk);
    status_set <= st;
    diag_set <= dg;
    next_id_load <= ld;
    next_id_in <= nid;
    @(posedge mclk);
    status_set <= 8'h00;
    diag_set <= 8'h00;
    next_id_load <= 1'b0;
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    {avs_read, avs_write, next_id_load} = 3'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    {status_set, diag_set, next_id_in} = 24'h000000;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    chk_bit("waitrequest in reset", 1'b1, avs_waitrequest);
    chk_bit("soft_reset in reset", 1'b0, soft_reset);
    @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // every register starts at zero
    for (int i = 0; i < 8; i++)
      rdc("reset value", 8'(i * 4), 8'h00);
    $display("test reset done");
    // table of plain accesses; upper pointer bits 5..3 always written zero
    foreach (rows[i])
    begin
      wr(rows[i].ofs, rows[i].wd);
      rdc("readback", rows[i].ofs, rows[i].exp);
      if (rows[i].ofs == CFG)
        chk_bit("chain_mode_enable", rows[i].exp[6], chain_mode_enable);
    end
    @(negedge mclk);
    chk_val("ram_addr", 32'h0000055A, {21'h0, ram_addr});
    wr(LO, 8'h33, 4'hE);
    rdc("lane 0 off", LO, 8'h5A);
    $display("test table done");
    // all eight select codes through the shared location
    for (int c = 0; c < 8; c++)
    begin
      wr(SEL, {5'h00, c[2:0]});
      wr(SH, 8'h30 | {5'h00, c[2:0]});
      rdc("shared", SH, (c == 3 || c > 4) ? 8'h00 : 8'h30 | {5'h00, c[2:0]});
    end
    chk_val("ids", 32'h30313234, {tentative_id, node_id, setup_one, setup_two});
    pulse(8'h81, 8'h42, 1'b1, 8'hA7);
    wr(SEL, 8'h03);
    rdc("next id", SH, 8'hA7);
    rdc("status", ST, 8'h81);
    rdc("diag", DG, 8'h42);
    $display("test select done");
    // software reset clears only status, next id and diagnostics
    wr(CFG, 8'hC0);
    @(negedge mclk);
    chk_bit("soft_reset", 1'b1, soft_reset);
    chk_bit("chain in reset", 1'b1, chain_mode_enable);
    rdc("status cleared", ST, 8'h00);
    rdc("diag cleared", DG, 8'h00);
    rdc("next id cleared", SH, 8'h00);
    rdc("config kept", CFG, 8'hC0);
    rdc("select kept", SEL, 8'h03);
    rdc("pointer kept", LO, 8'h5A);
    chk_val("tentative kept", 32'h00000030, {24'h0, tentative_id});
    pulse(8'h01, 8'h01, 1'b1, 8'h55);
    rdc("status held", ST, 8'h00);
    chk_val("next id held", 32'h00000000, {24'h0, next_id});
    wr(CFG, 8'h40);
    @(negedge mclk);
    chk_bit("soft_reset off", 1'b0, soft_reset);
    pulse(8'h02, 8'h00, 1'b0, 8'h00);
    rdc("status after", ST, 8'h02);
    $display("test soft reset done");
    // ram write with step, carry from lower into upper half
    wr(UP, 8'h41);
    wr(LO, 8'hFF);
    wr(RD, 8'hD1);
    wr(RD, 8'hD2);
    repeat (3) @(posedge mclk);
    chk_val("ram 1FF", 32'h000000D1, {24'h0, u_ram.mem[11'h1FF]});
    chk_val("ram 200", 32'h000000D2, {24'h0, u_ram.mem[11'h200]});
    rdc("lower step", LO, 8'h01);
    rdc("upper carry", UP, 8'h42);
    // write while prepared for read is ignored, then two stepping reads
    wr(UP, 8'hC1);
    wr(LO, 8'hFF);
    wr(RD, 8'hEE);
    rdc("ram rd 1FF", RD, 8'hD1);
    rdc("ram rd 200", RD, 8'hD2);
    rdc("lower after rd", LO, 8'h01);
    wr(UP, 8'h41);
    rdc("read dir 0", RD, 8'h00);
    rdc("no step dir 0", LO, 8'h01);
    // step disabled: same place twice
    wr(UP, 8'h81);
    wr(LO, 8'h10);
    rdc("hold 1", RD, 8'h11);
    rdc("hold 2", RD, 8'h11);
    rdc("lower held", LO, 8'h10);
    // top of the buffer wraps to zero
    wr(UP, 8'hC7);
    wr(LO, 8'hFF);
    rdc("ram 7FF", RD, 8'hF8);
    rdc("wrap lower", LO, 8'h00);
    rdc("wrap upper", UP, 8'hC0);
    @(negedge mclk);
    chk_val("ram_addr wrap", 32'h00000000, {21'h0, ram_addr});
    $display("test ram port done");
    summarize();
  end
endmodule
`default_nettype wire
